// [design/ssw_pkg.sv]
// Package of offsets, field positions and serial framing constants for the port status bank
package ssw_pkg;

   // Register indices on the serial counter table
   localparam logic [6:0] SSW_OFF_PORT_STATUS_A = 7'h01;
   localparam logic [6:0] SSW_OFF_PORT_STATUS_B = 7'h02;
   localparam logic [6:0] SSW_OFF_CABLE_BREAK   = 7'h03;
   localparam logic [6:0] SSW_OFF_RX_OVF_FLAGS  = 7'h3a;

   // Reset value shared by every word
   localparam logic [31:0] SSW_RESET_WORD = 32'h0000_0000;

   // Port count and per-port field positions
   localparam int SSW_PORTS = 5;
   // Lowest bit of each port nibble: link, then speed, duplex, flow control above it
   localparam int SSW_STAT_POS [SSW_PORTS] = '{0, 8, 16, 24, 28};
   localparam int SSW_SPEED_OFS = 1;
   localparam int SSW_DUPLEX_OFS = 2;
   localparam int SSW_FLOW_OFS = 3;
   // Cable break length field low bit; flag sits two above it
   localparam int SSW_CABLE_POS [SSW_PORTS] = '{0, 6, 12, 18, 21};
   localparam int SSW_CABLE_FLAG_OFS = 2;
   // Receive counter overflow flag positions
   localparam int SSW_PKT_OVF_POS [SSW_PORTS] = '{0, 2, 4, 6, 7};
   localparam int SSW_BYTE_OVF_POS [SSW_PORTS] = '{9, 11, 13, 15, 16};

   // Serial framing
   localparam logic [5:0] SSW_PREAMBLE_MIN = 6'h20;
   localparam logic [1:0] SSW_OP_READ      = 2'h2;
   localparam logic       SSW_TSEL_COUNTER = 1'h1;
   localparam logic [5:0] SSW_OP_BITS      = 6'h02;
   localparam logic [5:0] SSW_ADDR_BITS    = 6'h07;
   localparam logic [5:0] SSW_TA_BITS      = 6'h02;
   localparam logic [5:0] SSW_DATA_BITS    = 6'h20;

   // Serial frame states, Gray coded along the frame
   typedef enum logic [2:0] {
      SSW_ST_PRE   = 3'h0,
      SSW_ST_START = 3'h1,
      SSW_ST_OP    = 3'h3,
      SSW_ST_TSEL  = 3'h2,
      SSW_ST_ADDR  = 3'h6,
      SSW_ST_TA    = 3'h7,
      SSW_ST_DATA  = 3'h5
   } ssw_state_e;

endpackage : ssw_pkg

// [design/ssw_status_regs.sv]
// Port status, cable break and receive overflow registers with serial read port
`timescale 1ns/1ps

module ssw_status_regs (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_I,
   input  wire logic [4:0]  LINK_UP_I,
   input  wire logic [4:0]  SPEED_100_I,
   input  wire logic [4:0]  FULL_DUPLEX_I,
   input  wire logic [4:0]  FLOW_CTRL_I,
   input  wire logic [4:0]  CABLE_BROKEN_I,
   input  wire logic [9:0]  CABLE_LEN_I,
   input  wire logic [4:0]  RX_PKT_WRAP_I,
   input  wire logic [4:0]  RX_BYTE_WRAP_I,
   input  wire logic        SER_CLK_I,
   input  wire logic        SER_SEL_I,
   input  wire logic        SER_DATA_I,
   output logic             SER_DATA_O,
   output logic             SER_DATA_OE_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // State record

   typedef struct packed {
      logic                 sclk_prev;
      ssw_pkg::ssw_state_e  state;
      logic [5:0]           cnt;
      logic [1:0]           op;
      logic                 tsel;
      logic [6:0]           addr;
      logic [31:0]          shreg;
      logic                 dout;
      logic                 oe;
      logic [4:0]           pkt_ovf;
      logic [4:0]           byte_ovf;
      logic [31:0]          stat_a;
      logic [31:0]          cable;
   } ssw_regs_s;

   ssw_regs_s r;
   ssw_regs_s next_r;

   localparam ssw_regs_s SSW_REGS_RESET = '{
      sclk_prev: 1'b0,
      state:     ssw_pkg::SSW_ST_PRE,
      cnt:       6'h00,
      op:        2'h0,
      tsel:      1'b0,
      addr:      7'h00,
      shreg:     ssw_pkg::SSW_RESET_WORD,
      dout:      1'b0,
      oe:        1'b0,
      pkt_ovf:   5'h00,
      byte_ovf:  5'h00,
      stat_a:    ssw_pkg::SSW_RESET_WORD,
      cable:     ssw_pkg::SSW_RESET_WORD
   };

   ////////////////////////////////////////////////////////////////////////////////
   // Combinational word views

   logic        sclk_rise;
   logic [31:0] live_stat;
   logic [31:0] live_cable;
   logic [31:0] ovf_word;
   logic [31:0] read_word;
   logic        ovf_read;

   // Serial clock is synchronous to the core clock, so a plain edge compare is safe
   assign sclk_rise = SER_CLK_I & ~r.sclk_prev & ~SER_SEL_I;

   // Per-port field placement; every bit not placed stays zero
   always_comb begin
      live_stat  = ssw_pkg::SSW_RESET_WORD;
      live_cable = ssw_pkg::SSW_RESET_WORD;
      ovf_word   = ssw_pkg::SSW_RESET_WORD;
      for (int p = 0; p < ssw_pkg::SSW_PORTS; p++) begin
         live_stat[ssw_pkg::SSW_STAT_POS[p]] = LINK_UP_I[p];
         live_stat[ssw_pkg::SSW_STAT_POS[p] + ssw_pkg::SSW_SPEED_OFS] =
            SPEED_100_I[p];
         live_stat[ssw_pkg::SSW_STAT_POS[p] + ssw_pkg::SSW_DUPLEX_OFS] =
            FULL_DUPLEX_I[p];
         live_stat[ssw_pkg::SSW_STAT_POS[p] + ssw_pkg::SSW_FLOW_OFS] =
            FLOW_CTRL_I[p];
         live_cable[ssw_pkg::SSW_CABLE_POS[p] +: 2] = CABLE_LEN_I[2*p +: 2];
         live_cable[ssw_pkg::SSW_CABLE_POS[p] + ssw_pkg::SSW_CABLE_FLAG_OFS] =
            CABLE_BROKEN_I[p];
         ovf_word[ssw_pkg::SSW_PKT_OVF_POS[p]]  = r.pkt_ovf[p];
         ovf_word[ssw_pkg::SSW_BYTE_OVF_POS[p]] = r.byte_ovf[p];
      end
   end

   // Read data selection by register index; unlisted indices read zero
   always_comb begin
      unique case (r.addr)
         ssw_pkg::SSW_OFF_PORT_STATUS_A: read_word = r.stat_a;
         ssw_pkg::SSW_OFF_PORT_STATUS_B: read_word = ssw_pkg::SSW_RESET_WORD;
         ssw_pkg::SSW_OFF_CABLE_BREAK:   read_word = r.cable;
         ssw_pkg::SSW_OFF_RX_OVF_FLAGS:  read_word = ovf_word;
         default:                        read_word = ssw_pkg::SSW_RESET_WORD;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_r           = r;
      next_r.sclk_prev = SER_CLK_I;
      next_r.stat_a    = live_stat;
      next_r.cable     = live_cable;
      ovf_read         = 1'b0;

      // Serial frame decoder, advanced on each serial clock rising edge
      if (SER_SEL_I) begin
         next_r.state = ssw_pkg::SSW_ST_PRE;
         next_r.cnt   = 6'h00;
         next_r.oe    = 1'b0;
      end else if (sclk_rise) begin
         unique case (r.state)
            ssw_pkg::SSW_ST_PRE: begin
               if (SER_DATA_I) begin
                  if (r.cnt < ssw_pkg::SSW_PREAMBLE_MIN) begin
                     next_r.cnt = r.cnt + 6'h01;
                  end
               end else if (r.cnt == ssw_pkg::SSW_PREAMBLE_MIN) begin
                  next_r.state = ssw_pkg::SSW_ST_START;
                  next_r.cnt   = 6'h00;
               end else begin
                  next_r.cnt = 6'h00;
               end
            end
            ssw_pkg::SSW_ST_START: begin
               next_r.state = SER_DATA_I ? ssw_pkg::SSW_ST_OP : ssw_pkg::SSW_ST_PRE;
            end
            ssw_pkg::SSW_ST_OP: begin
               next_r.op  = {r.op[0], SER_DATA_I};
               next_r.cnt = r.cnt + 6'h01;
               if (r.cnt + 6'h01 == ssw_pkg::SSW_OP_BITS) begin
                  next_r.cnt = 6'h00;
                  // Only the read opcode is honoured
                  next_r.state = ({r.op[0], SER_DATA_I} == ssw_pkg::SSW_OP_READ) ?
                                 ssw_pkg::SSW_ST_TSEL : ssw_pkg::SSW_ST_PRE;
               end
            end
            ssw_pkg::SSW_ST_TSEL: begin
               next_r.tsel  = SER_DATA_I;
               next_r.state = ssw_pkg::SSW_ST_ADDR;
            end
            ssw_pkg::SSW_ST_ADDR: begin
               next_r.addr = {r.addr[5:0], SER_DATA_I};
               next_r.cnt  = r.cnt + 6'h01;
               if (r.cnt + 6'h01 == ssw_pkg::SSW_ADDR_BITS) begin
                  next_r.cnt   = 6'h00;
                  next_r.state = ssw_pkg::SSW_ST_TA;
               end
            end
            ssw_pkg::SSW_ST_TA: begin
               next_r.cnt = r.cnt + 6'h01;
               if (r.cnt == 6'h00) begin
                  // Snapshot the word so it cannot change mid-shift
                  next_r.shreg = read_word;
                  ovf_read = r.tsel == ssw_pkg::SSW_TSEL_COUNTER &&
                             r.addr == ssw_pkg::SSW_OFF_RX_OVF_FLAGS;
               end
               if (r.cnt + 6'h01 == ssw_pkg::SSW_TA_BITS) begin
                  next_r.cnt   = 6'h00;
                  next_r.state = ssw_pkg::SSW_ST_DATA;
                  next_r.oe    = r.tsel == ssw_pkg::SSW_TSEL_COUNTER;
                  next_r.dout  = r.shreg[31];
               end
            end
            ssw_pkg::SSW_ST_DATA: begin
               next_r.shreg = {r.shreg[30:0], 1'b0};
               next_r.dout  = r.shreg[30];
               next_r.cnt   = r.cnt + 6'h01;
               if (r.cnt + 6'h01 == ssw_pkg::SSW_DATA_BITS) begin
                  next_r.cnt   = 6'h00;
                  next_r.oe    = 1'b0;
                  next_r.dout  = 1'b0;
                  next_r.state = ssw_pkg::SSW_ST_PRE;
               end
            end
            default: begin
               next_r.state = ssw_pkg::SSW_ST_PRE;
               next_r.cnt   = 6'h00;
            end
         endcase
      end

      // Data line rests low whenever the output is not enabled (table 0, abort, idle)
      next_r.dout = next_r.dout & next_r.oe;

      // Sticky overflow flags: cleared by the read snapshot, a new wrap wins
      if (ovf_read) begin
         next_r.pkt_ovf  = 5'h00;
         next_r.byte_ovf = 5'h00;
      end
      next_r.pkt_ovf  = next_r.pkt_ovf | RX_PKT_WRAP_I;
      next_r.byte_ovf = next_r.byte_ovf | RX_BYTE_WRAP_I;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         r <= SSW_REGS_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Serial outputs straight from flip-flops
   assign SER_DATA_O    = r.dout;
   assign SER_DATA_OE_O = r.oe;

endmodule : ssw_status_regs

// [tb/ssw_status_regs_asserts.sv]
// Checker for the serial read timing of the port status bank
`timescale 1ns/1ps
module ssw_chk (
   input wire logic       CLK_SYS_I,
   input wire logic       RST_I,
   input wire logic [4:0] LINK_UP_I,
   input wire logic [4:0] SPEED_100_I,
   input wire logic [4:0] FULL_DUPLEX_I,
   input wire logic [4:0] FLOW_CTRL_I,
   input wire logic [4:0] CABLE_BROKEN_I,
   input wire logic [9:0] CABLE_LEN_I,
   input wire logic [4:0] RX_PKT_WRAP_I,
   input wire logic [4:0] RX_BYTE_WRAP_I,
   input wire logic       SER_CLK_I,
   input wire logic       SER_SEL_I,
   input wire logic       SER_DATA_I,
   input wire logic       SER_DATA_O,
   input wire logic       SER_DATA_OE_O
);
   logic       sclk_q;
   logic [5:0] cnt;
   wire        srise = SER_CLK_I & ~sclk_q & ~SER_SEL_I;
   // Last serial clock level and data rises seen in the current word
   always_ff @(posedge CLK_SYS_I) begin
      sclk_q <= SER_CLK_I;
      if (RST_I || !SER_DATA_OE_O) cnt <= 6'h00;
      else if (srise) cnt <= cnt + 6'h01;
   end
   default clocking dcb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RST_I);
   // Output change follows a serial rise by one or two clocks
   sequence s_after_rise;
      $past(srise) || $past(srise, 2);
   endsequence
   a_rel_quiet: assert property ($fell(RST_I) |-> !SER_DATA_OE_O && !SER_DATA_O)
      else $error("serial output active after reset");
   a_oe_launch: assert property ($rose(SER_DATA_OE_O) |-> s_after_rise)
      else $error("drive started without a serial rise");
   a_oe_release: assert property ($fell(SER_DATA_OE_O) |-> s_after_rise)
      else $error("drive ended without a serial rise");
   a_word_len: assert property ($fell(SER_DATA_OE_O) && !$past(SER_SEL_I) |-> cnt == 6'h20)
      else $error("word not 32 bits long");
   a_bit_stand: assert property ((SER_DATA_OE_O && $past(SER_DATA_OE_O) && !$past(srise)
      && !$past(srise, 2)) |-> $stable(SER_DATA_O)) else $error("bit changed between rises");
   a_idle_low: assert property (!SER_DATA_OE_O |-> !SER_DATA_O)
      else $error("data high while not driving");
   a_oe_hold: assert property ($rose(SER_DATA_OE_O) |-> SER_DATA_OE_O [*2])
      else $error("drive too short");
   a_sel_abort: assert property (SER_SEL_I |-> ##[1:2] !SER_DATA_OE_O)
      else $error("drive kept while deselected");
endmodule : ssw_chk

bind ssw_status_regs ssw_chk u_chk (.CLK_SYS_I, .RST_I, .LINK_UP_I, .SPEED_100_I,
   .FULL_DUPLEX_I, .FLOW_CTRL_I, .CABLE_BROKEN_I, .CABLE_LEN_I, .RX_PKT_WRAP_I,
   .RX_BYTE_WRAP_I, .SER_CLK_I, .SER_SEL_I, .SER_DATA_I, .SER_DATA_O, .SER_DATA_OE_O);

// [tb/ssw_host.sv]
// Management controller model issuing serial read frames
`timescale 1ns/1ps
module ssw_host (
   input  wire logic clk_i,
   input  wire logic dio_i,
   input  wire logic oe_i,
   output logic      sclk_o,
   output logic      sel_o,
   output logic      dout_o
);
   int   hp = 1;
   // Data bits read before the frame is cut by deselect; 0 reads the whole word
   int   cut = 0;
   logic seen;
   logic smp;
   // Idle: clock still, select high
   initial {sclk_o, sel_o, dout_o} = 3'h2;
   // One serial clock: data set while low, line read just before the rise
   task automatic cyc(input logic b);
      dout_o = b;
      sclk_o = 1'b0;
      repeat (hp) @(negedge clk_i);
      smp    = dio_i;
      seen   = seen | oe_i;
      sclk_o = 1'b1;
      repeat (hp) @(negedge clk_i);
   endtask : cyc
   // One frame; line toggles each clock while released
   task automatic rd(input logic [1:0] op, input logic ts, input logic [6:0] a,
                     input int npre, output logic [31:0] w);
      logic [11:0] c;
      c     = {2'h1, op, ts, a};
      seen  = 1'b0;
      sel_o = 1'b0;
      cyc(1'b0);
      repeat (npre) cyc(1'b1);
      for (int i = 11; i >= 0; i--) cyc(c[i]);
      for (int i = 33; i >= 0; i--) begin
         if (cut > 0 && i == 31 - cut) break;
         cyc(~dout_o);
         if (i < 32) w[i] = smp;
      end
      cyc(~dout_o);
      {sclk_o, sel_o, dout_o} = {2'h1, ~dout_o};
      // Keep deselect up for whole clocks before any next frame
      repeat (2) @(negedge clk_i);
   endtask : rd
endmodule : ssw_host

// [tb/ssw_status_regs_tb.sv]
// Self-checking bench for the port status register bank
`timescale 1ns/1ps
module ssw_status_regs_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  link = '0, spd = '0, dup = '0, flow = '0, brk = '0, pw = '0, bw = '0;
   logic [9:0]  clen = '0;
   logic        sclk, sel, hd, dout, oe;
   wire         dio = oe ? dout : hd;
   int          failures = 0;
   int          num_checks = 0;
   logic [31:0] w;
   // Core clock at 50 MHz
   always #10 clk = ~clk;
   ssw_status_regs u_dut (.CLK_SYS_I(clk), .RST_I(rst), .LINK_UP_I(link), .SPEED_100_I(spd),
      .FULL_DUPLEX_I(dup), .FLOW_CTRL_I(flow), .CABLE_BROKEN_I(brk), .CABLE_LEN_I(clen),
      .RX_PKT_WRAP_I(pw), .RX_BYTE_WRAP_I(bw), .SER_CLK_I(sclk), .SER_SEL_I(sel),
      .SER_DATA_I(dio), .SER_DATA_O(dout), .SER_DATA_OE_O(oe));
   ssw_host u_host (.clk_i(clk), .dio_i(dio), .oe_i(oe), .sclk_o(sclk), .sel_o(sel),
      .dout_o(hd));
   // Compare and count
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Expected status or cable word from the live inputs
   function automatic logic [31:0] word_exp(input logic cable);
      int          sp [5] = '{0, 8, 16, 24, 28};
      int          cp [5] = '{0, 6, 12, 18, 21};
      logic [31:0] e;
      e = '0;
      for (int p = 0; p < 5; p++) begin
         if (cable) e[cp[p] +: 3] = {brk[p], clen[2*p +: 2]};
         else e[sp[p] +: 4] = {flow[p], dup[p], spd[p], link[p]};
      end
      return e;
   endfunction : word_exp
   task automatic rdchk(input string what, input logic [6:0] a, input logic [31:0] e);
      u_host.rd(2'h2, 1'b1, a, 32, w);
      chk(what, w, e);
   endtask : rdchk
   // Words read zero straight after reset
   task automatic t_reset();
      logic [6:0] al [4] = '{7'h01, 7'h02, 7'h03, 7'h3a};
      foreach (al[i]) rdchk("reset_word", al[i], 32'h0);
   endtask : t_reset
   // Pattern and its inverse, second pass with a slow host
   task automatic t_status();
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         {link, spd, dup, flow, brk, clen} = k ? 35'h5_5a36_91ca : 35'h2_a5c9_6e35;
         u_host.hp = k + 1;
         rdchk("status_a", 7'h01, word_exp(1'b0));
         rdchk("status_b", 7'h02, 32'h0);
         rdchk("cable", 7'h03, word_exp(1'b1));
      end
      u_host.hp = 1;
   endtask : t_status
   // One-clock wrap pulses latch, then clear on read
   task automatic t_ovf();
      for (int k = 0; k < 2; k++) begin
         @(negedge clk);
         {pw, bw} = k ? 10'h155 : 10'h2aa;
         @(negedge clk);
         {pw, bw} = 10'h000;
         rdchk("ovf_set", 7'h3a, k ? 32'h0001_2244 : 32'h0000_8891);
         rdchk("ovf_clr", 7'h3a, 32'h0);
      end
   endtask : t_ovf
   // Bad opcode, other table and short preamble get no drive
   task automatic t_refuse();
      u_host.rd(2'h1, 1'b1, 7'h01, 32, w);
      chk("bad_op", {31'h0, u_host.seen}, 32'h0);
      u_host.rd(2'h2, 1'b0, 7'h01, 32, w);
      chk("tsel_0", {31'h0, u_host.seen}, 32'h0);
      u_host.rd(2'h2, 1'b1, 7'h01, 31, w);
      chk("short_pre", {31'h0, u_host.seen}, 32'h0);
      rdchk("unmapped", 7'h05, 32'h0);
   endtask : t_refuse
   // Wrap on the very edge of the clearing snapshot survives to the next read
   task automatic t_ovf_race();
      @(negedge clk);
      {pw, bw} = 10'h020;
      @(negedge clk);
      {pw, bw} = 10'h000;
      fork
         rdchk("race_old", 7'h3a, 32'h0000_0001);
         begin
            repeat (46) @(posedge sclk);
            {pw, bw} = 10'h201;
            @(negedge clk);
            {pw, bw} = 10'h000;
         end
      join
      rdchk("race_new", 7'h3a, 32'h0000_0280);
   endtask : t_ovf_race
   // Frame cut by deselect after eight data bits; drive stops, next read is whole
   task automatic t_abort();
      logic [31:0] e;
      @(negedge clk);
      {link, spd, dup, flow, brk, clen} = 35'h7_0f1e_2d3c;
      e = word_exp(1'b0);
      u_host.cut = 8;
      u_host.rd(2'h2, 1'b1, 7'h01, 32, w);
      u_host.cut = 0;
      chk("abort_hi", {24'h0, w[31:24]}, {24'h0, e[31:24]});
      chk("abort_oe", {31'h0, oe}, 32'h0);
      rdchk("abort_next", 7'h01, e);
   endtask : t_abort
   // Reset in mid-run clears latched flags; status words follow live inputs again
   task automatic t_rerst();
      @(negedge clk);
      pw = 5'h1f;
      @(negedge clk);
      pw = 5'h00;
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      rdchk("rerst_ovf", 7'h3a, 32'h0);
      rdchk("rerst_stat", 7'h01, word_exp(1'b0));
   endtask : t_rerst
   task automatic test_done();
      if (failures == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_reset();
      t_status();
      t_ovf();
      t_ovf_race();
      t_refuse();
      t_abort();
      t_rerst();
      test_done();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      test_done();
   end
endmodule : ssw_status_regs_tb
